// ==== verilog/serial_rx.v ====
// Serial clocking chain and receive path with Avalon-MM registers
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`include "serial_rx_defs.vh"
// What this block does
// - Six-bit prescaler runs at quarter source rate
// - Prescaler taps divide by 1, 4, 16, 64
// - Prescaler runs only when baud generator selected
// - Two-bit field picks generator input tap
// - Integer division by N from 1 to 16
// - Fraction ignored while fractional division off
// - Fractional division by N plus (16-K)/16
// - Sync output clock halves generator output
// - Sync input clock uses pin, edge selected
// - Async clock from generator, sysclk, timer, pin
// - Timer source gives bit per 16 pulses
// - Four-bit counter, 16 clocks, samples 7-9
// - Each async bit is majority of three samples, except with sysclk source (one sample)
// - Start valid when two samples are zero
// - Sync mode samples on selected clock edge
// - First buffer fills, moves to second, done pulse
// - Modes: sync, 7-bit, 8-bit, 9-bit async
// - Ninth bit flags address versus data
// - Overrun loses new character, keeps second buffer
module serial_rx (
  input  wire        ref_clk,        // System clock, 100 MHz
  input  wire        reset_n,        // Asynchronous reset, active low
  input  wire [3:0]  avs_address,    // Word address
  input  wire        avs_read,       // Read strobe
  input  wire        avs_write,      // Write strobe
  input  wire [31:0] avs_writedata,  // Write data
  input  wire [3:0]  avs_byteenable, // Byte lanes
  output reg  [31:0] avs_readdata,   // Read data
  output reg         avs_waitrequest,// Stall
  input  wire        rx_data,        // Receive data pin
  input  wire        sclk_in,        // Serial clock pin input
  input  wire        timer_trigger_output, // Timer trigger pulse
  output reg         sclk_out,       // Serial clock pin output
  output reg         sclk_oe_n,      // Low while driving clock pin
  output reg         receive_done_interrupt, // One-cycle done pulse
  output reg         overrun_ff      // Overrun level flag
);
  // ==========================================================
  // Registers
  reg [7:0] system_clock_config_ff;
  reg [7:0] baud_generator_control_ff;
  reg [7:0] baud_fraction_register_ff;
  reg [7:0] serial_control_register_ff;
  reg [7:0] serial_mode_register_ff;
  reg [8:0] receive_second_buffer_ff;
  reg       full_ff;
  reg       access_ff;

  wire [1:0] prescaler_source_select  = system_clock_config_ff[1:0];
  wire [3:0] integer_divisor_field    =
    baud_generator_control_ff[`BGC_DIV_LSB+3:`BGC_DIV_LSB];
  wire [1:0] generator_input_select   =
    baud_generator_control_ff[`BGC_CK_LSB+1:`BGC_CK_LSB];
  wire       fractional_divide_enable =
    baud_generator_control_ff[`BGC_FRAC_EN];
  wire [3:0] fraction_field           = baud_fraction_register_ff[3:0];
  wire       serial_clock_edge_select =
    serial_control_register_ff[`SCR_EDGE];
  wire       serial_clock_direction   =
    serial_control_register_ff[`SCR_DIR];
  wire       rx_enable = serial_control_register_ff[`SCR_RX_EN];
  wire [1:0] clock_source_field       =
    serial_mode_register_ff[`SMR_SRC_LSB+1:`SMR_SRC_LSB];
  wire [1:0] mode = serial_mode_register_ff[`SMR_MODE_LSB+1:`SMR_MODE_LSB];
  wire       sync_mode = (mode == `MODE_SYNC);

  // ==========================================================
  // Prescaler source: quarter of the gear-selected rate
  reg  [3:0] gear_cnt_ff;
  reg  [1:0] quarter_ff;
  reg        src_tick;
  always @* begin
    case (prescaler_source_select)
      2'h0:    src_tick = 1'b1;
      2'h2:    src_tick = (gear_cnt_ff == 4'hf);
      default: src_tick = 1'b1;
    endcase
  end
  // Uses baud generator only when it feeds the serial clock
  wire use_baud = sync_mode ? ~serial_clock_direction
                            : (clock_source_field == `SRC_BAUD);
  wire pre_tick = use_baud & src_tick & (quarter_ff == `PRE_QUARTER);
  reg  [5:0] pre_ff;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gear_cnt_ff <= 4'h0;
      quarter_ff  <= 2'h0;
      pre_ff      <= 6'h00;
    end else if (!use_baud) begin
      gear_cnt_ff <= 4'h0;
      quarter_ff  <= 2'h0;
      pre_ff      <= 6'h00;
    end else begin
      gear_cnt_ff <= gear_cnt_ff + 4'h1;
      if (src_tick)
        quarter_ff <= quarter_ff + 2'h1;
      if (pre_tick)
        pre_ff <= pre_ff + 6'h01;
    end
  end
  // Taps: every tick, every 4th, 16th, 64th
  reg tap_tick;
  always @* begin
    case (generator_input_select)
      2'h0:    tap_tick = pre_tick;
      2'h1:    tap_tick = pre_tick & (pre_ff[1:0] == 2'h3);
      2'h2:    tap_tick = pre_tick & (pre_ff[3:0] == 4'hf);
      default: tap_tick = pre_tick & (pre_ff == 6'h3f);
    endcase
  end

  // ==========================================================
  // Baud generator: count in sixteenths to allow fractional N
  reg  [8:0] acc_ff;
  wire [4:0] n_eff = (integer_divisor_field == 4'h0) ? 5'h10
                     : {1'b0, integer_divisor_field};
  // Fraction term is forced to zero when disabled
  wire [4:0] frac = fractional_divide_enable
                    ? (5'h10 - {1'b0, fraction_field}) : 5'h00;
  wire [8:0] period16 = {n_eff, 4'h0} + {4'h0, frac};
  wire [8:0] acc_inc  = acc_ff + 9'h010;
  wire       baud_tick = tap_tick & (acc_inc >= period16);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      acc_ff <= 9'h000;
    else if (!use_baud)
      acc_ff <= 9'h000;
    else if (tap_tick)
      acc_ff <= baud_tick ? (acc_inc - period16) : acc_inc;
  end

  // ==========================================================
  // Serial clock pin and timer trigger edge detection (pins sampled directly)
  reg sclk_in_d_ff;
  reg trg_d_ff;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_in_d_ff <= 1'b0;
      trg_d_ff     <= 1'b0;
    end else begin
      sclk_in_d_ff <= sclk_in;
      trg_d_ff     <= timer_trigger_output;
    end
  end
  wire ext_rise = sclk_in & ~sclk_in_d_ff;
  wire ext_fall = ~sclk_in & sclk_in_d_ff;
  wire trg_rise = timer_trigger_output & ~trg_d_ff;

  // ==========================================================
  // Basic serial clock selection
  reg basic_serial_clock;
  always @* begin
    case (clock_source_field)
      `SRC_TIMER:  basic_serial_clock = trg_rise;
      `SRC_BAUD:   basic_serial_clock = baud_tick;
      `SRC_SYSCLK: basic_serial_clock = 1'b1;
      default:     basic_serial_clock = ext_rise;
    endcase
  end
  wire sys_src = (clock_source_field == `SRC_SYSCLK);

  // Sync output clock: toggle on each generator tick, halving it
  reg sync_shift;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_out  <= 1'b1;
      sclk_oe_n <= 1'b1;
    end else begin
      sclk_oe_n <= ~(sync_mode & ~serial_clock_direction);
      if (sync_mode & ~serial_clock_direction & baud_tick)
        sclk_out <= ~sclk_out;
    end
  end
  always @* begin
    if (!sync_mode)
      sync_shift = 1'b0;
    else if (serial_clock_direction)
      sync_shift = serial_clock_edge_select ? ext_fall : ext_rise;
    else
      sync_shift = baud_tick & (serial_clock_edge_select ? sclk_out
                                                         : ~sclk_out);
  end

  // ==========================================================
  // Receive controller
  localparam ST_IDLE = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] state_ff;
  reg [3:0] phase_ff;
  reg [2:0] samp_ff;
  reg [3:0] bit_ff;
  reg [8:0] first_buffer_ff;
  // Majority of three samples
  wire maj = (samp_ff[0] & samp_ff[1]) | (samp_ff[0] & samp_ff[2]) |
             (samp_ff[1] & samp_ff[2]);
  // Character bits after start, stop included
  reg [3:0] char_bits;
  always @* begin
    case (mode)
      `MODE_UART7: char_bits = 4'h8;
      `MODE_UART8: char_bits = 4'h9;
      `MODE_UART9: char_bits = 4'ha;
      default:     char_bits = 4'h8;
    endcase
  end
  wire tick_rx = basic_serial_clock & ~sync_mode;
  // Sampling on 7th-9th clock; with sysclk the middle one only
  wire at_eval = sys_src ? (phase_ff == `SAMPLE_B)
                         : (phase_ff == `SAMPLE_C + 4'h1);
  wire bit_val = sys_src ? rx_data : maj;
  reg  done_pulse;
  reg  [8:0] done_char;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff        <= ST_IDLE;
      phase_ff        <= 4'h0;
      samp_ff         <= 3'h7;
      bit_ff          <= 4'h0;
      first_buffer_ff <= 9'h000;
      done_pulse      <= 1'b0;
      done_char       <= 9'h000;
    end else begin
      done_pulse <= 1'b0;
      if (!rx_enable) begin
        state_ff <= ST_IDLE;
        bit_ff   <= 4'h0;
      end else if (sync_mode) begin
        if (sync_shift) begin
          first_buffer_ff <= {1'b0, rx_data, first_buffer_ff[7:1]};
          if (bit_ff == 4'h7) begin
            bit_ff     <= 4'h0;
            done_pulse <= 1'b1;
            done_char  <= {1'b0, rx_data, first_buffer_ff[7:1]};
          end else
            bit_ff <= bit_ff + 4'h1;
        end
      end else if (tick_rx) begin
        case (state_ff)
          ST_IDLE: begin
            if (!rx_data) begin
              state_ff <= ST_DATA;
              phase_ff <= 4'h1;
              bit_ff   <= 4'h0;
            end
          end
          ST_DATA: begin
            phase_ff <= phase_ff + 4'h1;
            if (phase_ff == `SAMPLE_A || phase_ff == `SAMPLE_B ||
                phase_ff == `SAMPLE_C)
              samp_ff <= {samp_ff[1:0], rx_data};
            if (at_eval) begin
              if (bit_ff == 4'h0) begin
                if (bit_val)
                  state_ff <= ST_IDLE;
                else
                  bit_ff <= 4'h1;
              end else if (bit_ff == char_bits) begin
                state_ff <= ST_DONE; // Stop bit reached
              end else begin
                first_buffer_ff <= {bit_val, first_buffer_ff[8:1]};
                bit_ff <= bit_ff + 4'h1;
              end
            end
          end
          ST_DONE: begin
            state_ff   <= ST_IDLE;
            done_pulse <= 1'b1;
            if (mode == `MODE_UART7)
              done_char <= {2'b00, first_buffer_ff[8:2]};
            else if (mode == `MODE_UART8)
              done_char <= {1'b0, first_buffer_ff[8:1]};
            else
              done_char <= first_buffer_ff;
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end
  // The vote waits one tick after the third sample, so all three
  // samples belong to the same bit and none is left from the last.

  // ==========================================================
  // Second buffer and bus slave; read of data clears full
  // Full clears at the edge the read data is latched, so a character
  // landing at that edge is never dropped unseen
  wire rd_data = ~access_ff & avs_read &
                 (avs_address == `OFS_RECEIVE_SECOND_BUFFER);
  wire wr_en   = access_ff & avs_write & avs_byteenable[0];
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      receive_second_buffer_ff <= 9'h000;
      full_ff                  <= 1'b0;
      overrun_ff               <= 1'b0;
      receive_done_interrupt   <= 1'b0;
    end else begin
      receive_done_interrupt <= 1'b0;
      if (done_pulse && full_ff && !rd_data) begin
        overrun_ff <= 1'b1;
      end else if (done_pulse) begin
        receive_second_buffer_ff <= done_char;
        full_ff                  <= 1'b1;
        receive_done_interrupt   <= 1'b1;
      end else if (rd_data)
        full_ff <= 1'b0;
      if (wr_en && avs_address == `OFS_RECEIVE_STATUS &&
          avs_writedata[1] && !(done_pulse && full_ff && !rd_data))
        overrun_ff <= 1'b0; // Set wins over clear
    end
  end

  // One wait state per access, then answer; read data is loaded
  // as the request is taken so it already stands at the edge where
  // the master sees waitrequest low
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      access_ff                  <= 1'b0;
      avs_waitrequest            <= 1'b1;
      avs_readdata               <= 32'h0000_0000;
      system_clock_config_ff     <= `RST_SYSCFG;
      baud_generator_control_ff  <= `RST_BGC;
      baud_fraction_register_ff  <= `RST_FRAC;
      serial_control_register_ff <= `RST_SCR;
      serial_mode_register_ff    <= `RST_SMR;
    end else begin
      access_ff       <= (avs_read | avs_write) & ~access_ff;
      avs_waitrequest <= ~((avs_read | avs_write) & ~access_ff);
      if (wr_en) begin
        case (avs_address)
          `OFS_SYSTEM_CLOCK_CONFIG:
            system_clock_config_ff <= avs_writedata[7:0];
          `OFS_BAUD_GENERATOR_CONTROL:
            baud_generator_control_ff <= avs_writedata[7:0];
          `OFS_BAUD_FRACTION_REGISTER:
            baud_fraction_register_ff <= avs_writedata[7:0];
          `OFS_SERIAL_CONTROL_REGISTER:
            serial_control_register_ff <= avs_writedata[7:0];
          `OFS_SERIAL_MODE_REGISTER:
            serial_mode_register_ff <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (avs_read && !access_ff) begin
        case (avs_address)
          `OFS_SYSTEM_CLOCK_CONFIG:
            avs_readdata <= {24'h00_0000, system_clock_config_ff};
          `OFS_BAUD_GENERATOR_CONTROL:
            avs_readdata <= {24'h00_0000, baud_generator_control_ff};
          `OFS_BAUD_FRACTION_REGISTER:
            avs_readdata <= {24'h00_0000, baud_fraction_register_ff};
          `OFS_SERIAL_CONTROL_REGISTER:
            avs_readdata <= {24'h00_0000, serial_control_register_ff};
          `OFS_SERIAL_MODE_REGISTER:
            avs_readdata <= {24'h00_0000, serial_mode_register_ff};
          `OFS_RECEIVE_SECOND_BUFFER:
            avs_readdata <= {23'h00_0000, receive_second_buffer_ff};
          `OFS_RECEIVE_STATUS:
            avs_readdata <= {29'h0000_0000, state_ff != ST_IDLE,
                             overrun_ff, full_ff};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ==== verilog/serial_rx_defs.vh ====
// Register offsets, field positions and timing constants of the serial receiver
`ifndef SERIAL_RX_DEFS_VH
`define SERIAL_RX_DEFS_VH
// Register word addresses, compared directly with the Avalon-MM word address
`define OFS_SYSTEM_CLOCK_CONFIG     4'h0
`define OFS_BAUD_GENERATOR_CONTROL  4'h1
`define OFS_BAUD_FRACTION_REGISTER  4'h2
`define OFS_SERIAL_CONTROL_REGISTER 4'h3
`define OFS_SERIAL_MODE_REGISTER    4'h4
`define OFS_RECEIVE_SECOND_BUFFER   4'h5
`define OFS_RECEIVE_STATUS          4'h6
// Baud generator control fields
`define BGC_DIV_LSB    0
`define BGC_CK_LSB     4
`define BGC_FRAC_EN    6
// Serial control fields
`define SCR_EDGE       0
`define SCR_DIR        1
`define SCR_RX_EN      2
// Serial mode fields
`define SMR_SRC_LSB    0
`define SMR_MODE_LSB   2
// Mode encodings
`define MODE_SYNC      2'h0
`define MODE_UART7     2'h1
`define MODE_UART8     2'h2
`define MODE_UART9     2'h3
// Asynchronous clock sources
`define SRC_TIMER      2'h0
`define SRC_BAUD       2'h1
`define SRC_SYSCLK     2'h2
`define SRC_EXTPIN     2'h3
// Reset values
`define RST_SYSCFG     8'h00
`define RST_BGC        8'h01
`define RST_FRAC       8'h00
`define RST_SCR        8'h00
`define RST_SMR        8'h05
// Oversampling, sample points and prescaler quarter phase
`define OVERSAMPLE     5'h10
`define SAMPLE_A       4'h6
`define SAMPLE_B       4'h7
`define SAMPLE_C       4'h8
`define PRE_QUARTER    2'h3
`endif

// ==== tb/serial_rx_monitor.sv ====
// Port-level concurrent checks for the serial receiver
`timescale 1ns/10ps
module serial_rx_monitor (
  input wire        ref_clk,                // System clock
  input wire        reset_n,                // Async reset, low
  input wire [3:0]  avs_address,            // Word address
  input wire        avs_read,               // Read strobe
  input wire        avs_write,              // Write strobe
  input wire [31:0] avs_writedata,          // Write data
  input wire [3:0]  avs_byteenable,         // Byte lanes
  input wire [31:0] avs_readdata,           // Read data
  input wire        avs_waitrequest,        // Stall
  input wire        sclk_out,               // Clock pin out
  input wire        sclk_oe_n,              // Clock pin drive
  input wire        receive_done_interrupt, // Done pulse
  input wire        overrun_ff              // Overrun flag
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Completed write of one to the overrun bit of status
  wire clr_req = avs_write && !avs_waitrequest && avs_address == 4'h6
                 && avs_byteenable[0] && avs_writedata[1];
  // ==========================================================
  // Bus handshake steps
  sequence s_request;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // ==========================================================
  // Checks
  chk_bus_answer: assert property (s_request |=> s_answer)
    else $error("bus answer not one cycle after request");
  chk_idle_wait: assert property
    (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without request");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_address > 4'h6 |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  chk_done_gap: assert property (
    receive_done_interrupt |=> !receive_done_interrupt [*8])
    else $error("done pulses too close");
  chk_ovr_no_done: assert property (
    $rose(overrun_ff) |-> !receive_done_interrupt ##1 !receive_done_interrupt)
    else $error("done pulse on overrun");
  chk_ovr_sticky: assert property (
    overrun_ff && !clr_req |=> overrun_ff)
    else $error("overrun flag lost");
  chk_ovr_clear: assert property (clr_req && overrun_ff |=> !overrun_ff)
    else $error("overrun flag not cleared");
  chk_sclk_hold: assert property (
    $changed(sclk_out) && !sclk_oe_n && !$past(sclk_oe_n)
    |=> $stable(sclk_out) [*3])
    else $error("clock out toggles too fast");
endmodule

// ==== tb/remote_station.sv ====
// Remote serial station model driving the receive and clock pins
`timescale 1ns/10ps
module remote_station (
  input  wire  ref_clk, // System clock
  output logic rx_data, // Serial data line, idles high
  output logic sclk_in  // Serial clock line
);
  logic ext_run = 1'b0;
  logic ph      = 1'b0;
  // Lines idle at mark with the clock still
  initial begin
    rx_data = 1'b1;
    sclk_in = 1'b0;
  end
  // Pin clock of four cycles, run only when the bench asks
  always @(posedge ref_clk) begin
    if (ext_run) begin
      ph <= ~ph;
      if (ph) sclk_in <= ~sclk_in;
    end
  end
  // Start, data bits LSB first, stop; each bit held bl cycles
  task send_async(input logic [8:0] d, input int nb, input int bl);
    int i;
    rx_data <= 1'b0;
    repeat (bl) @(posedge ref_clk);
    for (i = 0; i < nb; i++) begin
      rx_data <= d[i];
      repeat (bl) @(posedge ref_clk);
    end
    rx_data <= 1'b1;
    repeat (bl) @(posedge ref_clk);
  endtask
  // Short low pulse that must not pass as a start bit
  task glitch(input int n);
    rx_data <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rx_data <= 1'b1;
    @(posedge ref_clk);
  endtask
  // Shift frame with 16-cycle clock; data set half a period early
  task send_sync(input logic [7:0] d, input logic idle);
    int i;
    for (i = 0; i < 8; i++) begin
      rx_data <= d[i];
      repeat (8) @(posedge ref_clk);
      sclk_in <= ~idle;
      repeat (8) @(posedge ref_clk);
      sclk_in <= idle;
    end
    repeat (8) @(posedge ref_clk);
    rx_data <= 1'b1;
  endtask
endmodule

// ==== tb/serial_rx_tb.sv ====
// Self-checking bench for the serial receiver
`timescale 1ns/10ps
module serial_rx_tb;
  localparam logic [39:0] RST_VALS = 40'h05_0000_0100;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h1;
  logic        timer_trigger_output = 1'b0;
  logic [1:0]  tph = 2'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, rx_data, sclk_in, sclk_out, sclk_oe_n;
  wire         receive_done_interrupt, overrun_ff;
  int          mismatches = 0;
  int          n_compared = 0;
  int          n_done = 0;
  // Device and far-side station
  serial_rx u_serial_rx (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_data(rx_data), .sclk_in(sclk_in), .sclk_out(sclk_out),
    .timer_trigger_output(timer_trigger_output), .sclk_oe_n(sclk_oe_n),
    .receive_done_interrupt(receive_done_interrupt), .overrun_ff(overrun_ff));
  remote_station u_remote_station (.ref_clk(ref_clk), .rx_data(rx_data),
    .sclk_in(sclk_in));
  // Clock, timer trigger every four cycles, done counter
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    tph <= tph + 2'h1;
    timer_trigger_output <= tph[1];
    if (receive_done_interrupt === 1'b1) n_done <= n_done + 1;
  end
  // ==========================================================
  // Shared tasks
  task check_eq(input logic [31:0] s, input logic [31:0] e, input string m);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, m, s, e);
    end
  endtask
  // A clock edge passes after release so strobes never retoggle at once
  task bus_wr(input logic [3:0] a, input logic [7:0] d);
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= 1'b1;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task bus_rd(input logic [3:0] a, output logic [31:0] r);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    r = avs_readdata;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task wait_done(input int n0, input int lim);
    int i;
    for (i = 0; i < lim && n_done == n0; i++) @(posedge ref_clk);
  endtask
  // One async character: one done, full set, data, full cleared by read
  task recv(input logic [8:0] d, input int nb, input int bl);
    int n0;
    logic [31:0] r;
    n0 = n_done;
    u_remote_station.send_async(d, nb, bl);
    wait_done(n0, 3 * bl + 40);
    check_eq(n_done - n0, 1, "done count");
    bus_rd(4'h6, r);
    check_eq(r & 32'h0000_0001, 32'h0000_0001, "full set");
    bus_rd(4'h5, r);
    check_eq(r, {23'h00_0000, d}, "char");
    bus_rd(4'h6, r);
    check_eq(r & 32'h0000_0001, 32'h0000_0000, "full clear");
  endtask
  task src_case(input logic [1:0] src, input logic [7:0] bgc,
                input logic [7:0] k, input int bl, input logic [7:0] d);
    u_remote_station.ext_run <= (src == 2'h3);
    bus_wr(4'h1, bgc);
    bus_wr(4'h2, k);
    bus_wr(4'h4, {4'h0, 2'h2, src});
    recv({1'b0, d}, 8, bl);
  endtask
  // Period of the driven clock, measured once the new setting settles
  task sclk_case(input logic [7:0] sys, input logic [7:0] bgc,
                 input logic [7:0] k, input int exp);
    time t0;
    bus_wr(4'h0, sys);
    bus_wr(4'h1, bgc);
    bus_wr(4'h2, k);
    repeat (2) @(posedge sclk_out);
    t0 = $time;
    @(posedge sclk_out);
    @(posedge ref_clk);
    check_eq(int'(($time - t0) / 10) - 1, exp, "period");
    check_eq({31'h0, sclk_oe_n}, 32'h0000_0000, "pin driven");
  endtask
  // ==========================================================
  // Scenarios
  task t_reset_values;
    int i;
    logic [31:0] r;
    for (i = 0; i < 5; i++) begin
      bus_rd(i[3:0], r);
      check_eq(r, {24'h00_0000, RST_VALS[8*i +: 8]}, "reset value");
    end
    bus_rd(4'h9, r);
    check_eq(r, 32'h0000_0000, "unmapped read");
  endtask
  task t_sources;
    bus_wr(4'h3, 8'h04);
    src_case(2'h0, 8'h01, 8'h00, 64, 8'hA5);
    src_case(2'h1, 8'h01, 8'h00, 64, 8'h5A);
    src_case(2'h1, 8'h42, 8'h08, 160, 8'hC3);
    src_case(2'h2, 8'h01, 8'h00, 16, 8'h3C);
    src_case(2'h3, 8'h01, 8'h00, 64, 8'h99);
    u_remote_station.ext_run <= 1'b0;
    bus_wr(4'h1, 8'h01);
    bus_wr(4'h2, 8'h00);
  endtask
  task t_modes;
    bus_wr(4'h4, 8'h05);
    recv(9'h05A, 7, 64);
    bus_wr(4'h4, 8'h0D);
    recv(9'h1A6, 9, 64);
    recv(9'h0A6, 9, 64);
    bus_wr(4'h4, 8'h09);
  endtask
  task t_glitch;
    int n0;
    n0 = n_done;
    u_remote_station.glitch(8);
    repeat (128) @(posedge ref_clk);
    check_eq(n_done - n0, 0, "glitch taken as start");
    recv(9'h03C, 8, 64);
  endtask
  // Second character lands on a full buffer and is lost
  task t_overrun;
    int n0;
    logic [31:0] r;
    n0 = n_done;
    u_remote_station.send_async(9'h055, 8, 64);
    wait_done(n0, 232);
    u_remote_station.send_async(9'h0AA, 8, 64);
    repeat (232) @(posedge ref_clk);
    check_eq(n_done - n0, 1, "done on overrun");
    check_eq({31'h0, overrun_ff}, 32'h0000_0001, "overrun set");
    bus_rd(4'h5, r);
    check_eq(r, 32'h0000_0055, "buffer kept");
    bus_wr(4'h6, 8'h02);
    check_eq({31'h0, overrun_ff}, 32'h0000_0000, "overrun cleared");
  endtask
  // External shift clock, both sampling edges
  task t_sync_in;
    int e, n0;
    logic [7:0] d;
    logic [31:0] r;
    bus_wr(4'h4, 8'h00);
    for (e = 0; e < 2; e++) begin
      d = e ? 8'hB2 : 8'h6D;
      bus_wr(4'h3, 8'h00);
      u_remote_station.sclk_in <= e[0];
      repeat (4) @(posedge ref_clk);
      bus_wr(4'h3, {5'h00, 2'h3, e[0]});
      @(posedge ref_clk);
      check_eq({31'h0, sclk_oe_n}, 32'h0000_0001, "pin released");
      n0 = n_done;
      u_remote_station.send_sync(d, e[0]);
      wait_done(n0, 64);
      bus_rd(4'h5, r);
      check_eq(r, {24'h00_0000, d}, "sync char");
    end
    bus_wr(4'h3, 8'h00);
  endtask
  // Fraction enable stays clear in shift mode
  task t_sync_out;
    bus_wr(4'h3, 8'h04);
    sclk_case(8'h00, 8'h01, 8'h00, 8);
    sclk_case(8'h00, 8'h13, 8'h05, 96);
    sclk_case(8'h00, 8'h20, 8'h00, 2048);
    sclk_case(8'h00, 8'h32, 8'h00, 1024);
    sclk_case(8'h02, 8'h01, 8'h00, 128);
  endtask
  // ==========================================================
  // Verdict, main sequence and watchdog
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset_values;
    $display("reset values test ends");
    t_sources;
    $display("clock sources test ends");
    t_modes;
    $display("modes test ends");
    t_glitch;
    $display("start glitch test ends");
    t_overrun;
    $display("overrun test ends");
    t_sync_in;
    $display("shift input test ends");
    t_sync_out;
    $display("shift output test ends");
    give_verdict;
  end
  initial begin
    #500_000;
    mismatches++;
    give_verdict;
  end
endmodule
bind serial_rx serial_rx_monitor u_serial_rx_monitor (.ref_clk(ref_clk),
  .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sclk_out(sclk_out),
  .sclk_oe_n(sclk_oe_n), .receive_done_interrupt(receive_done_interrupt),
  .overrun_ff(overrun_ff));
